// [shared/apd_pkg.sv]
// package: constants, types and helpers of the adc power-down controller
// Function
// - shutdown high: enabled, internal compensation, 225kHz
// - shutdown floating: enabled, external compensation, 1.8MHz
// - shutdown low: hardware power-down, selections void
// - hardware power-down abandons running conversion at once
// - power-select bits request power-down and clock mode
// - software down waits for current conversion end
// - internal mode: result still shifts out when down
// - first one on serial input powers up
// - upper select bit one keeps device powered
// - both select bits zero: one conversion, down
// - select codes: 00 full, 01 fast, 10/11 clock
// - shutdown low overrides the power-select bits
// - serial interface keeps working in software down
package apd_pkg;

    // clocks and conversion length
    localparam int unsigned HCLK_HZ         = 40_000_000;
    localparam int unsigned INT_CLK_SLOW_HZ = 225_000;
    localparam int unsigned INT_CLK_FAST_HZ = 1_800_000;
    localparam int unsigned EXT_CLK_HZ      = 2_000_000;
    localparam int unsigned CONV_CLKS       = 12;
    localparam int unsigned CONV_CYC_SLOW   = CONV_CLKS * HCLK_HZ / INT_CLK_SLOW_HZ;
    localparam int unsigned CONV_CYC_FAST   = CONV_CLKS * HCLK_HZ / INT_CLK_FAST_HZ;
    localparam int unsigned CONV_CYC_EXT    = CONV_CLKS * HCLK_HZ / EXT_CLK_HZ;
    localparam logic [11:0] CONV_LEN_SLOW   = 12'(CONV_CYC_SLOW);
    localparam logic [11:0] CONV_LEN_FAST   = 12'(CONV_CYC_FAST);
    localparam logic [11:0] CONV_LEN_EXT    = 12'(CONV_CYC_EXT);

    // register offsets (byte addresses)
    localparam logic [7:0] OFF_SAMPLE    = 8'h00;
    localparam logic [7:0] OFF_STATUS    = 8'h04;
    localparam logic [7:0] OFF_CTRL_BYTE = 8'h08;

    // status field positions
    localparam int unsigned ST_STATE    = 0;
    localparam int unsigned ST_BUSY     = 2;
    localparam int unsigned ST_CLK_EXT  = 3;
    localparam int unsigned ST_RATE     = 4;
    localparam int unsigned ST_COMP     = 5;
    localparam int unsigned ST_SEL      = 6;

    // reset values
    localparam logic [9:0] RST_SAMPLE  = 10'h000;
    localparam logic       RST_CLK_EXT = 1'b0;

    typedef enum logic [1:0] {
        pwr_hw_down,
        full_down_state,
        fast_down_state,
        pwr_active
    } apd_pwr_e;

    // serial control byte, start bit first
    typedef struct packed {
        logic       start;
        logic [4:0] cfg;
        logic       power_select_hi;
        logic       power_select_lo;
    } apd_ctl_byte_s;

    // three-state shutdown pin as seen by the sense circuit
    typedef struct packed {
        logic level;
        logic floating;
    } apd_shutdown_pin_n_s;

    // conversion length in hclk cycles for the chosen clock
    function automatic logic [11:0] conv_len(input logic ext, input logic fast);
        conv_len = ext ? CONV_LEN_EXT : (fast ? CONV_LEN_FAST : CONV_LEN_SLOW);
    endfunction

    // power state after a conversion ends for a select pair
    function automatic apd_pwr_e sel_to_state(input logic hi, input logic lo);
        if (hi) begin
            sel_to_state = pwr_active;
        end else begin
            sel_to_state = lo ? fast_down_state : full_down_state;
        end
    endfunction

endpackage

// [rtl/apd_sync.sv]
// two-flop synchroniser for a group of levels or toggles
`timescale 1ns/1ps
`default_nettype none
module apd_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } apd_sync_s;

    apd_sync_s r_q;
    apd_sync_s r_d;

    // first stage feeds only the second stage
    always_comb begin
        r_d = r_q;
        if (en) begin
            r_d.meta   = d;
            r_d.stable = r_q.meta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.stable;
endmodule
`default_nettype wire

// [rtl/apd_link.sv]
// serial-clock side: start bit, control byte capture, result shift-out
`timescale 1ns/1ps
`default_nettype none
module apd_link (
    input  wire logic       sclk,
    input  wire logic       rst_n,
    input  wire logic       cs_n,
    input  wire logic       din,
    input  wire logic       res_tgl,
    input  wire logic [9:0] res_data,
    output logic            start_tgl,
    output logic            byte_tgl,
    output logic [7:0]      ctl_byte,
    output logic            dout,
    output logic            dout_oe
);
    typedef struct packed {
        logic       rx_on;
        logic [2:0] cnt;
        logic [5:0] sh;
        logic [7:0] ctl;
        logic       start_tgl;
        logic       byte_tgl;
        logic       res_prev;
        logic [9:0] out_sh;
        logic       dout;
        logic       dout_oe;
    } apd_link_s;

    apd_link_s q;
    apd_link_s d;
    logic      res_s;

    // result toggle comes from the hclk domain
    apd_sync #(.W(1)) u_res_sync (
        .clk   (sclk),
        .rst_n (rst_n),
        .en    (1'b1),
        .d     (res_tgl),
        .q     (res_s)
    );

    // runs in every power state; only chip select gates it
    always_comb begin
        d          = q;
        d.res_prev = res_s;
        d.dout_oe  = !cs_n;
        if (res_s != q.res_prev) begin
            d.out_sh = res_data; // data held stable by sender until next toggle
        end else if (!cs_n) begin
            d.dout   = q.out_sh[9];
            d.out_sh = {q.out_sh[8:0], 1'b0};
        end
        if (cs_n) begin
            d.rx_on = 1'b0;
            d.dout  = 1'b0;
        end else if (!q.rx_on) begin
            if (din) begin
                d.rx_on     = 1'b1;
                d.cnt       = 3'h0;
                d.start_tgl = !q.start_tgl;
            end
        end else if (q.cnt == 3'h6) begin
            d.ctl      = {1'b1, q.sh, din};
            d.byte_tgl = !q.byte_tgl;
            d.rx_on    = 1'b0;
        end else begin
            d.sh  = {q.sh[4:0], din};
            d.cnt = q.cnt + 3'h1;
        end
    end

    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign start_tgl = q.start_tgl;
    assign byte_tgl  = q.byte_tgl;
    assign ctl_byte  = q.ctl;
    assign dout      = q.dout;
    assign dout_oe   = q.dout_oe;

    a_start_detect: assert property (@(posedge sclk) disable iff (!rst_n)
        (!cs_n && !q.rx_on && din) |=> (q.rx_on && start_tgl != $past(start_tgl)))
        else $error("start bit not taken");

    a_byte_eight_bits: assert property (@(posedge sclk) disable iff (!rst_n)
        (!cs_n && !q.rx_on && din) ##1 (!cs_n) [*7] |=> (byte_tgl != $past(byte_tgl, 8)))
        else $error("control byte not complete after eight bits");
endmodule
`default_nettype wire

// [rtl/apd_top.sv]
// power-state and conversion-clock control with ahb-lite register slave
//
// Added by the designer: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module apd_top (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial link
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe,
    // shutdown pin sense and status pins
    input  wire logic        shutdown_pin_n,
    input  wire logic        shutdown_float,
    output logic             conversion_strobe,
    output logic             int_clk_fast,
    output logic             comp_external,
    output apd_pkg::apd_pwr_e power_state
);
    typedef struct packed {
        apd_pkg::apd_pwr_e pstate;
        logic              busy;
        logic [11:0]       cnt;
        logic              clk_ext;
        logic [1:0]        sel;
        logic              rate_fast;
        logic              comp_ext;
        logic              strobe;
        logic [9:0]        sample;
        logic [9:0]        result;
        logic              res_tgl;
        logic [7:0]        last_byte;
        logic              start_prev;
        logic              byte_prev;
        logic              wr_pend;
        logic [7:0]        wr_addr;
        logic [31:0]       rdata;
        logic              ready;
        logic [1:0]        warm;
    } apd_top_s;

    apd_top_s q;
    apd_top_s d;

    apd_pkg::apd_shutdown_pin_n_s    shutdown_pin_n_s;
    apd_pkg::apd_ctl_byte_s ctl_w;
    logic [1:0]            tgl_s;
    logic                  start_tgl;
    logic                  byte_tgl;
    logic [7:0]            ctl_byte;
    logic                  hw_down;
    logic                  start_evt;
    logic                  byte_evt;
    logic                  done;
    logic                  addr_ok;
    logic [31:0]           status_w;

    // pin levels cross in from outside the clock domain
    apd_sync #(.W(2)) u_shutdown_pin_n_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .en    (ce),
        .d     ({shutdown_pin_n, shutdown_float}),
        .q     (shutdown_pin_n_s)
    );

    // event toggles from the serial clock domain
    apd_sync #(.W(2)) u_tgl_sync (
        .clk   (hclk),
        .rst_n (hresetn),
        .en    (ce),
        .d     ({start_tgl, byte_tgl}),
        .q     (tgl_s)
    );

    apd_link u_link (
        .sclk      (sclk),
        .rst_n     (hresetn),
        .cs_n      (cs_n),
        .din       (din),
        .res_tgl   (q.res_tgl),
        .res_data  (q.result),
        .start_tgl (start_tgl),
        .byte_tgl  (byte_tgl),
        .ctl_byte  (ctl_byte),
        .dout      (dout),
        .dout_oe   (dout_oe)
    );

    // control byte is stable once its toggle has been synchronised
    assign ctl_w     = apd_pkg::apd_ctl_byte_s'(ctl_byte);
    // pin ignored until the sync has filled, else its reset zeros read as pin low
    assign hw_down   = q.warm[1] && !shutdown_pin_n_s.floating && !shutdown_pin_n_s.level;
    assign start_evt = tgl_s[1] != q.start_prev;
    assign byte_evt  = tgl_s[0] != q.byte_prev;
    assign done      = q.busy && (q.cnt == 12'h001) && !hw_down && !byte_evt;
    assign addr_ok   = hsel && htrans[1] && hready;

    // status word seen by software
    always_comb begin
        status_w = '0;
        status_w[apd_pkg::ST_STATE +: 2] = q.pstate;
        status_w[apd_pkg::ST_BUSY]       = q.busy;
        status_w[apd_pkg::ST_CLK_EXT]    = q.clk_ext;
        status_w[apd_pkg::ST_RATE]       = q.rate_fast;
        status_w[apd_pkg::ST_COMP]       = q.comp_ext;
        status_w[apd_pkg::ST_SEL +: 2]   = q.sel;
    end

    // power machine, conversion timer and register slave
    always_comb begin
        d = q;
        if (ce) begin
            d.start_prev = tgl_s[1];
            d.byte_prev  = tgl_s[0];
            d.warm       = {q.warm[0], 1'b1};
            // rate and compensation follow the pin; floating means fast clock
            d.rate_fast  = shutdown_pin_n_s.floating;
            d.comp_ext   = shutdown_pin_n_s.floating;
            if (hw_down) begin
                // pin low wins over any byte; conversion dropped mid-way
                d.pstate = apd_pkg::pwr_hw_down;
                d.busy   = 1'b0;
                d.cnt    = 12'h000;
            end else begin
                if (q.pstate == apd_pkg::pwr_hw_down) begin
                    d.pstate = apd_pkg::pwr_active;
                end
                if (start_evt) begin
                    d.pstate = apd_pkg::pwr_active;
                end
                if (byte_evt) begin
                    // a new byte restarts any running conversion
                    d.last_byte = ctl_w;
                    d.sel       = {ctl_w.power_select_hi, ctl_w.power_select_lo};
                    if (ctl_w.power_select_hi) begin
                        d.clk_ext = ctl_w.power_select_lo;
                    end
                    d.busy   = 1'b1;
                    d.pstate = apd_pkg::pwr_active;
                    d.cnt    = apd_pkg::conv_len(d.clk_ext, d.rate_fast);
                end else if (done) begin
                    d.busy    = 1'b0;
                    d.cnt     = 12'h000;
                    d.result  = q.sample;
                    d.res_tgl = !q.res_tgl;
                    // down only after the result is in
                    d.pstate  = apd_pkg::sel_to_state(q.sel[1], q.sel[0]);
                end else if (q.busy) begin
                    d.cnt = q.cnt - 12'h001;
                end
            end
            d.strobe = !d.busy && (d.pstate != apd_pkg::pwr_hw_down);
            // data phase of a write
            if (q.wr_pend && (q.wr_addr == apd_pkg::OFF_SAMPLE)) begin
                d.sample = hwdata[9:0];
            end
            // address phase; zero wait states, so read data is prepared now
            d.ready = 1'b1;
            if (hready) begin
                d.wr_pend = addr_ok && hwrite && (hsize == 3'b010);
                d.wr_addr = haddr[7:0];
                d.rdata   = '0;
                if (addr_ok && !hwrite) begin
                    unique case (haddr[7:0])
                        apd_pkg::OFF_SAMPLE:    d.rdata = {22'h000000, q.sample};
                        apd_pkg::OFF_STATUS:    d.rdata = status_w;
                        apd_pkg::OFF_CTRL_BYTE: d.rdata = {24'h000000, q.last_byte};
                        default:                d.rdata = '0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q         <= '0;
            q.pstate  <= apd_pkg::pwr_active;
            q.clk_ext <= apd_pkg::RST_CLK_EXT;
            q.sample  <= apd_pkg::RST_SAMPLE;
            q.strobe  <= 1'b1;
            q.ready   <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign hrdata            = q.rdata;
    assign hreadyout         = q.ready;
    assign hresp             = 1'b0;
    assign conversion_strobe = q.strobe;
    assign int_clk_fast      = q.rate_fast;
    assign comp_external     = q.comp_ext;
    assign power_state       = q.pstate;

    // checks
    logic sw_down;
    assign sw_down = (q.pstate == apd_pkg::full_down_state) || (q.pstate == apd_pkg::fast_down_state);

    sequence s_conv_end;
        ce && done;
    endsequence

    sequence s_conv_end_low;
        ce && done && !q.sel[1];
    endsequence

    property p_sw_down_after_end;
        @(posedge hclk) disable iff (!hresetn)
        s_conv_end_low |=> sw_down && !q.busy;
    endproperty

    a_rate_pin_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && shutdown_pin_n_s.level && !shutdown_pin_n_s.floating) |=> (!int_clk_fast && !comp_external))
        else $error("pin high must give slow clock and internal compensation");

    a_rate_pin_float: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && shutdown_pin_n_s.floating) |=> (int_clk_fast && comp_external))
        else $error("floating pin must give fast clock and external compensation");

    a_hw_down_abort: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && hw_down && q.busy) |=> (power_state == apd_pkg::pwr_hw_down && !q.busy && !$changed(q.res_tgl)))
        else $error("conversion not dropped on hardware power-down");

    a_hw_down_wins: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && hw_down && byte_evt) |=> (power_state == apd_pkg::pwr_hw_down && !conversion_strobe))
        else $error("control byte overrode shutdown pin");

    a_sw_down_order: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(sw_down) |-> $past(done))
        else $error("software power-down before conversion end");

    a_sw_down_seq: assert property (p_sw_down_after_end)
        else $error("no power-down after single conversion");

    a_stay_up: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_conv_end and (q.sel[1] == 1'b1)) |=> (power_state == apd_pkg::pwr_active) [*1])
        else $error("device fell down with upper select bit set");

    a_start_powers_up: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && start_evt && !hw_down) |=> power_state == apd_pkg::pwr_active)
        else $error("start bit did not power up");

    a_clk_mode_kept: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && byte_evt && !hw_down && !ctl_w.power_select_hi) |=> $stable(q.clk_ext))
        else $error("clock mode lost across power-down byte");

    a_conv_length: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && byte_evt && !hw_down) |=> (q.cnt == apd_pkg::conv_len(q.clk_ext, q.rate_fast)))
        else $error("conversion length does not match clock mode");

    // timer and power state while a conversion runs
    a_conv_count: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && q.busy && !done && !hw_down && !byte_evt) |=> (q.cnt == $past(q.cnt) - 12'h001))
        else $error("conversion timer did not count down");

    a_up_in_conv: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && q.busy && !done && !hw_down) |=> (power_state == apd_pkg::pwr_active))
        else $error("powered down while converting");

    a_strobe_on_byte: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && byte_evt && !hw_down) |=> (!conversion_strobe && q.busy))
        else $error("control byte did not start a conversion");

    // end of conversion: result handed over, then the selected state
    a_result_on_end: assert property (@(posedge hclk) disable iff (!hresetn)
        s_conv_end |=> ($changed(q.res_tgl) && q.result == $past(q.sample)))
        else $error("result not handed to the link at conversion end");

    a_full_down_end: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && done && q.sel == 2'b00) |=> (power_state == apd_pkg::full_down_state))
        else $error("select pair 00 did not end in full power-down");

    a_fast_down_end: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && done && q.sel == 2'b01) |=> (power_state == apd_pkg::fast_down_state))
        else $error("select pair 01 did not end in fast power-down");

    // hardware power-down holds and drops bytes; leaving it goes to active
    a_hw_down_holds: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && hw_down) |=> (power_state == apd_pkg::pwr_hw_down && !conversion_strobe))
        else $error("pin low did not hold hardware power-down");

    a_hw_byte_dropped: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && hw_down && byte_evt) |=> ($stable(q.sel) && $stable(q.last_byte)))
        else $error("control byte taken during hardware power-down");

    a_hw_exit_up: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && !hw_down && power_state == apd_pkg::pwr_hw_down) |=> (power_state == apd_pkg::pwr_active))
        else $error("hardware power-down exit did not return to active");
endmodule
`default_nettype wire

// [tb/apd_host_model.sv]
// serial host model: drives link clock, select and data, reads results
`timescale 1ns/1ps
`default_nettype none
module apd_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout
);
    localparam realtime HALF = 62.5;

    // link clock starts low, with chip select released and data high
    initial begin
        sclk = 1'h0;
        cs_n = 1'h1;
        din  = 1'h1;
    end

    // one link clock period, data changes only while the clock is low
    task automatic pulse();
        #HALF sclk = 1'h1;
        #HALF sclk = 1'h0;
    endtask

    // released data line shows the inverse of its last value
    task automatic idle(input int n);
        cs_n = 1'h1;
        din  = ~din;
        repeat (n) pulse();
    endtask

    // control byte, start bit first, select pair in the two low bits
    task automatic send_byte(input logic [7:0] b);
        cs_n = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            din = b[i];
            pulse();
        end
        idle(0);
    endtask

    // result shift-out; zeros on the data input so no start bit is seen
    task automatic read_result(output logic [9:0] r);
        idle(4); // result load has to cross into the link domain first
        cs_n = 1'h0;
        din  = 1'h0;
        for (int i = 9; i >= 0; i--) begin
            #HALF sclk = 1'h1;
            #20 r[i] = dout;
            #(HALF - 20) sclk = 1'h0;
        end
        idle(0);
    endtask

    // settling after power-up; caller follows up with a checked conversion
    task automatic power_up_wait(input logic comp_ext);
        #2000;
        if (comp_ext) #75000;
        else #1600000;
    endtask
endmodule
`default_nettype wire

// [tb/apd_tb.sv]
// self-checking bench: register bus, link frames, shutdown pin
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, rdy_s, bad, last_ext, hresp;
    logic [31:0]       haddr, hwdata, hrdata, rd_s, rd;
    logic [1:0]        htrans;
    logic [2:0]        hsize;
    logic              sclk, cs_n, din, dout, dout_oe;
    logic              shutdown_pin_n, shutdown_float, conversion_strobe, int_clk_fast, comp_external;
    apd_pkg::apd_pwr_e power_state;
    logic [9:0]        res;
    int                n_mismatch, n_tests, lowcnt;

    apd_top apd_top_i (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .shutdown_pin_n(shutdown_pin_n),
        .shutdown_float(shutdown_float), .conversion_strobe(conversion_strobe),
        .int_clk_fast(int_clk_fast), .comp_external(comp_external), .power_state(power_state));
    apd_host_model apd_host_model_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    initial begin
        hclk = 1'h0;
        forever #12.5 hclk = ~hclk;
    end

    // bus values as they stood just before each rising edge
    always @(negedge hclk) begin
        rd_s  <= hrdata;
        rdy_s <= hreadyout;
    end

    // conversion length and state, sampled mid-cycle away from the launching edge
    always @(negedge hclk) begin
        if (conversion_strobe === 1'h0) begin
            lowcnt <= lowcnt + 1;
            if (power_state !== apd_pkg::pwr_active) bad <= 1'h1;
        end
    end

    task automatic summarize();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // single word transfer; each phase waits for the slave's ready
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'h1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= wr;
        hsize  <= 3'h2;
        do @(posedge hclk); while (rdy_s !== 1'h1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (rdy_s !== 1'h1);
        rd = rd_s;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'h0, a, 32'h0);
        chk(name, exp, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    function automatic logic [31:0] st(input logic [1:0] s, input logic e, input logic f, input logic [1:0] p);
        st = {24'h0, p, f, f, e, 1'h0, s};
    endfunction

    // one conversion through the link, then state, status and result
    task automatic convert(input logic fl, input logic [1:0] sel, input logic [9:0] smp);
        logic [11:0]       len;
        apd_pkg::apd_pwr_e exp_st;
        ahb(1'h1, apd_pkg::OFF_SAMPLE, {22'h0, smp});
        shutdown_float <= fl;
        repeat (5) @(posedge hclk);
        chk("rate_fast", {31'h0, fl}, {31'h0, int_clk_fast});
        chk("comp_ext", {31'h0, fl}, {31'h0, comp_external});
        if (sel[1]) last_ext = sel[0];
        len = last_ext ? apd_pkg::CONV_LEN_EXT : (fl ? apd_pkg::CONV_LEN_FAST : apd_pkg::CONV_LEN_SLOW);
        exp_st = sel[1] ? apd_pkg::pwr_active : (sel[0] ? apd_pkg::fast_down_state : apd_pkg::full_down_state);
        lowcnt <= 0;
        bad    <= 1'h0;
        apd_host_model_i.send_byte({1'h1, 5'h15, sel});
        repeat (40) if (conversion_strobe !== 1'h0) @(posedge hclk);
        while (conversion_strobe !== 1'h1) @(posedge hclk);
        repeat (2) @(posedge hclk);
        chk("conv_cycles", 32'(len), 32'(lowcnt));
        chk("state_in_conv", 32'h0, {31'h0, bad});
        chk("state_after", 32'(exp_st), 32'(power_state));
        rchk("status", apd_pkg::OFF_STATUS, st(exp_st, last_ext, fl, sel));
        rchk("ctl_byte", apd_pkg::OFF_CTRL_BYTE, {24'h0, 1'h1, 5'h15, sel});
        apd_host_model_i.read_result(res);
        chk("result", {22'h0, smp}, {22'h0, res});
    endtask

    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        shutdown_pin_n = 1'h1;
        shutdown_float = 1'h0;
        n_mismatch = 0;
        n_tests = 0;
        lowcnt = 0;
        bad = 1'h0;
        last_ext = apd_pkg::RST_CLK_EXT;
        fork
            apd_host_model_i.idle(3); // link domain needs edges during reset
        join_none
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        repeat (4) @(posedge hclk);
        chk("reset_state", 32'(apd_pkg::pwr_active), 32'(power_state));
        chk("reset_strobe", 32'h1, {31'h0, conversion_strobe});
        chk("reset_oe", 32'h0, {31'h0, dout_oe});
        ahb(1'h1, apd_pkg::OFF_SAMPLE, 32'hFFFFFFFF);
        rchk("sample_mask", apd_pkg::OFF_SAMPLE, 32'h3FF);
        rchk("unmapped", 8'h0C, 32'h0);
        // every select code, each down state left again by a start bit
        convert(1'h0, 2'h3, 10'h2A5);
        convert(1'h0, 2'h0, 10'h15A);
        convert(1'h0, 2'h2, 10'h3C1);
        convert(1'h1, 2'h1, 10'h07E);
        convert(1'h1, 2'h0, 10'h300);
        ahb(1'h1, apd_pkg::OFF_STATUS, 32'hFFFFFFFF);
        rchk("status_ro", apd_pkg::OFF_STATUS, st(apd_pkg::full_down_state, 1'h0, 1'h1, 2'h0));
        // conversion cut short by the pin, select bits overridden meanwhile
        apd_host_model_i.send_byte(8'hAA);
        repeat (30) @(posedge hclk);
        shutdown_pin_n <= 1'h0;
        shutdown_float <= 1'h0;
        repeat (4) @(posedge hclk);
        chk("hw_down", 32'(apd_pkg::pwr_hw_down), 32'(power_state));
        rchk("abort_busy", apd_pkg::OFF_STATUS, st(apd_pkg::pwr_hw_down, 1'h0, 1'h0, 2'h2));
        apd_host_model_i.send_byte(8'h83);
        repeat (20) @(posedge hclk);
        chk("override", 32'(apd_pkg::pwr_hw_down), 32'(power_state));
        shutdown_pin_n <= 1'h1;
        shutdown_float <= 1'h1;
        repeat (4) @(posedge hclk);
        chk("hw_exit", 32'(apd_pkg::pwr_active), 32'(power_state));
        apd_host_model_i.power_up_wait(shutdown_float);
        convert(1'h1, 2'h3, 10'h1C3);
        summarize();
    end

    // cuts a hang short
    initial begin
        repeat (40000) @(posedge hclk);
        n_mismatch++;
        summarize();
    end
endmodule
`default_nettype wire
